//--- i2c_master_slave_control_tb_top.sv
`timescale 1ns/10ps
module i2c_master_slave_control_tb_top;
  import i2cmsc_pkg::*;
  logic       clk, rst, wr, gie, sie, req, tovf, scl_oe, sda_oe, m_oe, so, do_;
  logic [7:0] addr, wdata, rdata;
  wire        scl_w = !scl_oe;
  wire        sda_w = !(sda_oe | m_oe);
  int         num_errors, checks_done;
  i2cmsc_ctrl uut (.clk(clk), .rst(rst), .scl_link_clk(scl_w), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .global_int_enable(gie), .serial_int_enable(sie),
    .serial_int_req(req), .timer_ovf(tovf), .scl_i(scl_w), .scl_o(so), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(do_), .sda_oe(sda_oe));
  i2cmsc_slave_model slv (.scl(scl_w), .sda(sda_w), .sda_oe(m_oe));
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) begin addr = a; wdata = d; wr = 1'b1; end
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) addr = a;
    repeat (2) @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_req();
    int n;
    for (n = 0; n < 3000 && req !== 1'b1; n++) @(negedge clk);
    if (req !== 1'b1) num_errors++;
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------
  // stimulus
  // ----------------
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100us num_errors++;
    print_verdict();
  end
  initial begin
    logic [7:0] v;
    int n;
    num_errors = 0; checks_done = 0;
    rst = 1; wr = 0; addr = 8'h00; wdata = 8'h00; gie = 1; sie = 1; tovf = 0;
    repeat (6) @(negedge clk);
    rst = 0;
    rd_reg(SFR_STAT, v); chk(v, ST_NONE);
    rd_reg(8'hF0, v); chk(v, 8'h00);
    wr_reg(SFR_CTRL, 8'hE6);
    wait_req();
    rd_reg(SFR_STAT, v); chk(v, ST_START);
    repeat (20) @(negedge clk);
    chk({7'h00, scl_oe}, 8'h01);
    @(negedge clk) gie = 1'b0;
    @(negedge clk) chk({7'h00, req}, 8'h00);
    gie = 1'b1;
    wr_reg(SFR_DATA, 8'hA0);
    wr_reg(SFR_CTRL, 8'hC6);
    wait_req();
    rd_reg(SFR_STAT, v); chk(v, ST_SLAW_ACK);
    wr_reg(SFR_CTRL, 8'hD6);
    for (n = 0; n < 100; n++) begin
      rd_reg(SFR_CTRL, v);
      if (v[4] === 1'b0) break;
    end
    chk(v, 8'hC6);
    chk({7'h00, req}, 8'h00);
    wr_reg(SFR_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    chk({6'h00, so, do_}, 8'h00);
    print_verdict();
  end
endmodule // i2c_master_slave_control_tb_top

//--- i2cmsc_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - start_request: START at once if bus free, else after STOP plus half bit.
// - start_request while master after bytes gives a repeated START.
// - start_request accepted any time; clear means no START generated.
// - stop_request as master drives STOP; cleared once STOP seen on bus.
// - stop_request as slave: internal STOP, not addressed, self-cleared.
// - both requests set: STOP first, then START.
// - serial_int_flag set on entry to every state except F8H.
// - interrupt request only when flag and both enables are set.
// - flag set holds SCL low; high SCL untouched; released on clear.
// - assert_ack set: acknowledge own address, general call, received data.
// - assert_ack clear: not acknowledge after received data bytes.
// - slave transmitter ends in C8H, then not addressed with SDA high.
// - not addressed: no address match, no ack, no interrupt, still monitors.
// - assert_ack set mid-address still lets the address be recognised.
// - in slave modes rate select is ignored; follows external SCL.
// - master rate select divides oscillator by 128,112,96,80,48,60,30.
// - rate select 111 divides timer overflow rate by 48.
// - status is 8-bit read-only, low three bits zero, F8H idle.
// - status valid one cycle after flag set until one after cleared.
// - unit disabled: pins float, inputs ignored, not addressed, stop cleared.
// - address compare on own_address_reg[7:1]; general call if bit 0 set.
module i2cmsc_ctrl
  import i2cmsc_pkg::*;
(
  // clocks and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_link_clk,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // interrupt request
  input  wire logic       global_int_enable,
  input  wire logic       serial_int_enable,
  output logic            serial_int_req,
  // neighbouring timer
  input  wire logic       timer_ovf,
  // open-drain bus pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [7:0] half_load(input logic [2:0] sel);
    logic [7:0] d;
    case (sel)
      3'h0:    d = DIV_0;
      3'h1:    d = DIV_1;
      3'h2:    d = DIV_2;
      3'h3:    d = DIV_3;
      3'h4:    d = DIV_4;
      3'h5:    d = DIV_5;
      3'h6:    d = DIV_6;
      default: d = DIV_TMR;
    endcase
    return 8'((d >> 1) - 8'h01);
  endfunction

  // bit under transfer, msb first
  function automatic logic tx_bit(input logic [7:0] d, input logic [3:0] b);
    return d[~b[2:0]];
  endfunction

  // ------------------------------------------------------------
  // link domain: shift in SDA on rising SCL
  // ------------------------------------------------------------
  logic [7:0] link_shift_reg;

  always_ff @(posedge scl_link_clk or posedge rst) begin
    if (rst) link_shift_reg <= 8'h00;
    else     link_shift_reg <= {link_shift_reg[6:0], sda_i};
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  i2cmsc_ctrl_t   ctrl_reg, ctrl_next;
  i2cmsc_mstate_t m_reg, m_next;
  i2cmsc_role_t   role_reg, role_next;
  i2cmsc_bus_ev_t ev;
  logic [2:0]     scl_sync_reg, sda_sync_reg;
  logic [7:0]     link_w1_reg, link_w2_reg;
  logic [7:0]     data_reg, data_next;
  logic [7:0]     own_reg;
  logic [7:0]     div_cnt_reg;
  logic [3:0]     bit_reg, bit_next;
  logic [3:0]     tx_idx_reg, tx_idx_next;
  logic           first_reg, first_next;
  logic           ack_reg, ack_next;
  logic           gc_reg, gc_next;
  logic           busy_reg, busy_next;
  logic           arb_reg, arb_next;
  logic           ackin_reg, ackin_next;
  logic           rep_reg;
  logic           stretch_reg, stretch_next;
  logic           scl_low_reg, sda_low_reg;
  logic [7:0]     stat_code_reg, stat_out_reg, rdata_reg;
  logic           si_set, sto_clr;
  logic [7:0]     si_code;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  i2cmsc_ctrl_t wr_val;
  wire          ens      = ctrl_reg.ens;
  wire          wr_ctrl  = sfr_wr && (sfr_addr == SFR_CTRL);
  wire          wr_data  = sfr_wr && (sfr_addr == SFR_DATA);
  wire          wr_own   = sfr_wr && (sfr_addr == SFR_OWN);
  wire          scl_q    = ens ? scl_sync_reg[1] : 1'b1;
  wire          sda_q    = ens ? sda_sync_reg[1] : 1'b1;
  wire          scl_qp   = ens ? scl_sync_reg[2] : 1'b1;
  wire          sda_qp   = ens ? sda_sync_reg[2] : 1'b1;
  wire          master   = !(m_reg == M_IDLE || m_reg == M_WAIT);
  wire [2:0]    rate_sel = {ctrl_reg.cr2, ctrl_reg.cr1, ctrl_reg.cr0};
  wire          div_step = (rate_sel != SEL_TMR) | timer_ovf;
  wire          half_tick = div_step && (div_cnt_reg == 8'h00);
  wire          tick_clr = (m_next != m_reg) | ev.stop | ((m_reg == M_HIGH) & ~scl_q);
  wire          addr_hit = link_w2_reg[7:1] == own_reg[7:1];
  wire          gc_hit   = (link_w2_reg[7:1] == 7'h00) & own_reg[0];
  wire          m_drive  = (m_reg == M_HOLD) | (m_reg == M_LOW) | (m_reg == M_HIGH);

  assign wr_val   = i2cmsc_ctrl_t'(sfr_wdata);
  assign ev.rise  = scl_q & ~scl_qp;
  assign ev.fall  = ~scl_q & scl_qp;
  assign ev.start = scl_q & scl_qp & sda_qp & ~sda_q;
  assign ev.stop  = scl_q & scl_qp & ~sda_qp & sda_q;

  // ------------------------------------------------------------
  // master sequencer
  // ------------------------------------------------------------
  always_comb begin
    m_next = m_reg;
    case (m_reg)
      M_IDLE: begin
        // a pending internal stop is served before the start
        if (ctrl_reg.start_request && !ctrl_reg.stop_request && !ctrl_reg.si) begin
          m_next = busy_reg ? M_WAIT : M_START;
        end
      end
      M_WAIT: if (!busy_reg && half_tick) m_next = M_START;
      M_START: if (half_tick) m_next = M_HOLD;
      M_HOLD: begin
        if (!ctrl_reg.si) begin
          if (ctrl_reg.stop_request)      m_next = M_P1;
          else if (ctrl_reg.start_request) m_next = M_RS1;
          else                   m_next = M_LOW;
        end
      end
      M_LOW: begin
        if (ctrl_reg.si)     m_next = M_HOLD;
        else if (half_tick)  m_next = M_HIGH;
      end
      M_HIGH: if (scl_q && half_tick) m_next = M_LOW;
      M_RS1: if (half_tick) m_next = M_RS2;
      M_RS2: if (scl_q && half_tick) m_next = M_START;
      M_P1: if (half_tick) m_next = M_P2;
      M_P2: if (scl_q && half_tick) m_next = M_IDLE;
      default: m_next = M_IDLE;
    endcase
    if (!ens || arb_next) m_next = M_IDLE;
  end

  // ------------------------------------------------------------
  // byte engine, follows the bus edges in every mode
  // ------------------------------------------------------------
  always_comb begin
    role_next  = role_reg;
    bit_next   = bit_reg;
    first_next = first_reg;
    ack_next   = ack_reg;
    gc_next    = gc_reg;
    busy_next  = busy_reg;
    arb_next   = 1'b0;
    ackin_next = ackin_reg;
    data_next  = wr_data ? sfr_wdata : data_reg;
    si_set     = 1'b0;
    si_code    = ST_NONE;
    sto_clr    = 1'b0;
    if (!ens || (wr_ctrl && !wr_val.ens)) begin
      role_next = R_NONE;
      ack_next  = 1'b0;
      busy_next = 1'b0;
    end else if (ev.start) begin
      busy_next  = 1'b1;
      bit_next   = 4'h0;
      first_next = 1'b1;
      ack_next   = 1'b0;
      gc_next    = 1'b0;
      if (role_reg == R_SRX || role_reg == R_STX) begin
        si_set  = 1'b1;
        si_code = ST_SLV_STOP;
      end
      role_next = master ? R_MTX : R_NONE;
      if (m_reg == M_START) begin
        si_set  = 1'b1;
        si_code = rep_reg ? ST_RSTART : ST_START;
      end
    end else if (ev.stop) begin
      busy_next = 1'b0;
      ack_next  = 1'b0;
      sto_clr   = ctrl_reg.stop_request;
      if (role_reg == R_SRX || role_reg == R_STX) begin
        si_set  = 1'b1;
        si_code = ST_SLV_STOP;
      end
      role_next = R_NONE;
    end else if (ctrl_reg.stop_request && !master) begin
      // recovery: behave as if a stop was seen, nothing on the wires
      sto_clr   = 1'b1;
      role_next = R_NONE;
      ack_next  = 1'b0;
      bit_next  = 4'h0;
    end else begin
      if (ev.rise && bit_reg < BIT_END) begin
        bit_next = 4'(bit_reg + 4'h1);
        if (bit_reg == BIT_ACK) ackin_next = sda_q;
        // drove a one but the wire is low: another master won
        if (role_reg == R_MTX && bit_reg < BIT_ACK && tx_bit(data_reg, bit_reg) && !sda_q) begin
          arb_next  = 1'b1;
          role_next = R_NONE;
        end
      end
      if (ev.fall && bit_reg == BIT_ACK) begin
        data_next = link_w2_reg;
        case (role_reg)
          R_NONE: begin
            if (first_reg && !master && ctrl_reg.aa) begin
              if (!link_w2_reg[0] && (addr_hit || gc_hit)) begin
                ack_next  = 1'b1;
                gc_next   = gc_hit && !addr_hit;
                role_next = R_SRX;
              end else if (link_w2_reg[0] && addr_hit) begin
                ack_next  = 1'b1;
                role_next = R_STX;
              end
            end
          end
          R_MRX:   ack_next = ctrl_reg.aa;
          R_SRX:   ack_next = ctrl_reg.aa;
          default: ack_next = 1'b0;
        endcase
      end
      if (ev.fall && bit_reg == BIT_END) begin
        bit_next   = 4'h0;
        first_next = 1'b0;
        ack_next   = 1'b0;
        si_set     = 1'b1;
        case (role_reg)
          R_MTX: begin
            if (first_reg && data_reg[0]) begin
              si_code   = ackin_reg ? ST_SLAR_NACK : ST_SLAR_ACK;
              role_next = R_MRX;
            end else if (first_reg) begin
              si_code = ackin_reg ? ST_SLAW_NACK : ST_SLAW_ACK;
            end else begin
              si_code = ackin_reg ? ST_TXD_NACK : ST_TXD_ACK;
            end
          end
          R_MRX: si_code = ack_reg ? ST_RXD_ACK : ST_RXD_NACK;
          R_SRX: begin
            if (first_reg)   si_code = gc_reg ? ST_GC_W : ST_OWN_W;
            else if (gc_reg) si_code = ack_reg ? ST_GCD_ACK : ST_GCD_NACK;
            else             si_code = ack_reg ? ST_SRXD_ACK : ST_SRXD_NACK;
            if (!first_reg && !ack_reg) role_next = R_NONE;
          end
          R_STX: begin
            if (first_reg)          si_code = ST_OWN_R;
            else if (ackin_reg)     si_code = ST_STXD_NACK;
            else if (ctrl_reg.aa)   si_code = ST_STXD_ACK;
            else                    si_code = ST_STX_LAST;
            if (!first_reg && (ackin_reg || !ctrl_reg.aa)) role_next = R_NONE;
          end
          default: begin
            si_set  = arb_reg;
            si_code = ST_ARB_LOST;
          end
        endcase
      end
      if (arb_reg && !(ev.fall && bit_reg == BIT_END)) arb_next = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // control register next value
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) ctrl_next = wr_val;
    // a software set of stop_request wins over the hardware clear; the hardware set of si wins over a write
    if (sto_clr && !(wr_ctrl && wr_val.stop_request)) ctrl_next.stop_request = 1'b0;
    if (si_set) ctrl_next.si = 1'b1;
    if (!ctrl_next.ens) ctrl_next.stop_request = 1'b0;
  end

  // only stretch a low already on the wire, never pull a high down
  assign stretch_next = ctrl_next.si & (stretch_reg | ~scl_q);

  wire scl_low_next = ctrl_next.ens & (stretch_next | (m_next == M_LOW) | (m_next == M_HOLD) |
                      (m_next == M_RS1) | (m_next == M_P1));
  // data bit moves only after a start or a falling SCL; a change while SCL is high reads as start or stop
  assign tx_idx_next = (ev.start | ev.fall) ? bit_next : tx_idx_reg;

  wire tx_drive     = (role_next == R_STX) | ((role_next == R_MTX) & m_drive);
  wire sda_low_next = ctrl_next.ens & (ack_next | (m_next == M_START) | (m_next == M_P1) |
                      (m_next == M_P2) | (tx_drive & (tx_idx_next < BIT_ACK) & ~tx_bit(data_next, tx_idx_next)));

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      link_w1_reg  <= 8'h00;
      link_w2_reg  <= 8'h00;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      // word is quiet while SCL is low, so it is stable when read
      link_w1_reg  <= link_shift_reg;
      link_w2_reg  <= link_w1_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= i2cmsc_ctrl_t'(CTRL_RST);
      own_reg  <= OWN_RST;
      data_reg <= DATA_RST;
      m_reg    <= M_IDLE;
      role_reg <= R_NONE;
    end else begin
      ctrl_reg <= ctrl_next;
      own_reg  <= wr_own ? sfr_wdata : own_reg;
      data_reg <= data_next;
      m_reg    <= m_next;
      role_reg <= role_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_reg   <= 4'h0;
      first_reg <= 1'b0;
      ack_reg   <= 1'b0;
      gc_reg    <= 1'b0;
      busy_reg  <= 1'b0;
      arb_reg   <= 1'b0;
      ackin_reg <= 1'b1;
      tx_idx_reg <= 4'h0;
    end else begin
      bit_reg   <= bit_next;
      first_reg <= first_next;
      ack_reg   <= ack_next;
      gc_reg    <= gc_next;
      busy_reg  <= busy_next;
      arb_reg   <= arb_next;
      ackin_reg <= ackin_next;
      tx_idx_reg <= tx_idx_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 8'h00;
      rep_reg     <= 1'b0;
    end else begin
      if (tick_clr || half_tick) div_cnt_reg <= half_load(rate_sel);
      else if (div_step)         div_cnt_reg <= 8'(div_cnt_reg - 8'h01);
      if (m_reg == M_IDLE)      rep_reg <= 1'b0;
      else if (m_reg == M_RS1)  rep_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stretch_reg   <= 1'b0;
      scl_low_reg   <= 1'b0;
      sda_low_reg   <= 1'b0;
      stat_code_reg <= ST_NONE;
      stat_out_reg  <= ST_NONE;
      rdata_reg     <= 8'h00;
    end else begin
      stretch_reg   <= stretch_next;
      scl_low_reg   <= scl_low_next;
      sda_low_reg   <= sda_low_next;
      stat_code_reg <= si_set ? si_code : stat_code_reg;
      stat_out_reg  <= ctrl_reg.si ? stat_code_reg : ST_NONE;
      rdata_reg     <= (sfr_addr == SFR_CTRL) ? ctrl_reg :
                       (sfr_addr == SFR_DATA) ? data_reg :
                       (sfr_addr == SFR_OWN)  ? own_reg  :
                       (sfr_addr == SFR_STAT) ? stat_out_reg : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sfr_rdata      = rdata_reg;
  assign serial_int_req = ctrl_reg.si & global_int_enable & serial_int_enable;
  assign scl_o          = 1'b0;
  assign sda_o          = 1'b0;
  assign scl_oe         = scl_low_reg;
  assign sda_oe         = sda_low_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_irq_gate;
    !ctrl_reg.si || !global_int_enable || !serial_int_enable |-> !serial_int_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enables");

  property p_stat_valid;
    $rose(ctrl_reg.si) |=> stat_out_reg == stat_code_reg && stat_out_reg != ST_NONE;
  endproperty
  a_stat_valid: assert property (p_stat_valid) else $error("status not valid after flag");

  property p_stat_low0;
    stat_out_reg[2:0] == 3'h0 and ($fell(ctrl_reg.si) |=> stat_out_reg == ST_NONE);
  endproperty
  a_stat_low0: assert property (p_stat_low0) else $error("status format wrong");

  property p_stretch;
    (ens && ctrl_reg.si && !scl_q) [*2] |-> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("low period not stretched");

  property p_disabled;
    !ens |-> !scl_oe && !sda_oe && !ctrl_reg.stop_request && role_reg == R_NONE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled unit touches bus");

  property p_slave_sto;
    ens && ctrl_reg.stop_request && !master && !ev.start && !ev.stop && !wr_ctrl |=> !ctrl_reg.stop_request ##0 role_reg == R_NONE;
  endproperty
  a_slave_sto: assert property (p_slave_sto) else $error("slave stop not self cleared");

  property p_start_free;
    m_reg == M_IDLE && ens && ctrl_reg.start_request && !ctrl_reg.stop_request && !ctrl_reg.si && !busy_reg
      |=> m_reg == M_START ##1 sda_oe;
  endproperty
  a_start_free: assert property (p_start_free) else $error("no start on free bus");

  property p_no_start;
    m_reg == M_IDLE && !ctrl_reg.start_request |=> m_reg == M_IDLE;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start without request");

  property p_ack_srx;
    role_reg == R_SRX && ev.fall && bit_reg == BIT_ACK && ctrl_reg.aa && !ctrl_reg.stop_request |=> sda_oe;
  endproperty
  a_ack_srx: assert property (p_ack_srx) else $error("missing acknowledge");

  property p_nack_mrx;
    role_reg == R_MRX && ev.fall && bit_reg == BIT_ACK && !ctrl_reg.aa |=> !sda_oe;
  endproperty
  a_nack_mrx: assert property (p_nack_mrx) else $error("acknowledge with assert_ack clear");

  property p_quiet;
    role_reg == R_NONE && m_reg == M_IDLE && !arb_reg |-> !si_set || si_code == ST_SLV_STOP;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt while not addressed");

  c_master_start: cover property (m_reg == M_START ##[1:300] m_reg == M_HOLD);
  c_rep_start:    cover property (ctrl_reg.si && stat_code_reg == ST_RSTART);
  c_own_addr:     cover property (ctrl_reg.si && stat_code_reg == ST_OWN_W);
  c_stop_seq:     cover property (m_reg == M_P2 ##[1:300] m_reg == M_IDLE);

endmodule // i2cmsc_ctrl

//--- i2cmsc_pkg.sv
package i2cmsc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] SFR_CTRL = 8'hD8;
  localparam logic [7:0] SFR_STAT = 8'hD9;
  localparam logic [7:0] SFR_DATA = 8'hDA;
  localparam logic [7:0] SFR_OWN  = 8'hDB;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] OWN_RST  = 8'h00;

  // ------------------------------------------------------------
  // status codes, low three bits always zero
  // ------------------------------------------------------------
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RSTART    = 8'h10;
  localparam logic [7:0] ST_SLAW_ACK  = 8'h18;
  localparam logic [7:0] ST_SLAW_NACK = 8'h20;
  localparam logic [7:0] ST_TXD_ACK   = 8'h28;
  localparam logic [7:0] ST_TXD_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB_LOST  = 8'h38;
  localparam logic [7:0] ST_SLAR_ACK  = 8'h40;
  localparam logic [7:0] ST_SLAR_NACK = 8'h48;
  localparam logic [7:0] ST_RXD_ACK   = 8'h50;
  localparam logic [7:0] ST_RXD_NACK  = 8'h58;
  localparam logic [7:0] ST_OWN_W     = 8'h60;
  localparam logic [7:0] ST_GC_W      = 8'h70;
  localparam logic [7:0] ST_SRXD_ACK  = 8'h80;
  localparam logic [7:0] ST_SRXD_NACK = 8'h88;
  localparam logic [7:0] ST_GCD_ACK   = 8'h90;
  localparam logic [7:0] ST_GCD_NACK  = 8'h98;
  localparam logic [7:0] ST_SLV_STOP  = 8'hA0;
  localparam logic [7:0] ST_OWN_R     = 8'hA8;
  localparam logic [7:0] ST_STXD_ACK  = 8'hB8;
  localparam logic [7:0] ST_STXD_NACK = 8'hC0;
  localparam logic [7:0] ST_STX_LAST  = 8'hC8;
  localparam logic [7:0] ST_NONE      = 8'hF8;

  // ------------------------------------------------------------
  // bit period divisors of the oscillator (clk), per rate select; DIV_TMR divides timer overflows
  // ------------------------------------------------------------
  localparam logic [7:0] DIV_0   = 8'h80;
  localparam logic [7:0] DIV_1   = 8'h70;
  localparam logic [7:0] DIV_2   = 8'h60;
  localparam logic [7:0] DIV_3   = 8'h50;
  localparam logic [7:0] DIV_4   = 8'h30;
  localparam logic [7:0] DIV_5   = 8'h3C;
  localparam logic [7:0] DIV_6   = 8'h1E;
  localparam logic [7:0] DIV_TMR = 8'h30;
  localparam logic [2:0] SEL_TMR = 3'h7;

  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic cr2;
    logic ens;
    logic start_request;
    logic stop_request;
    logic si;
    logic aa;
    logic cr1;
    logic cr0;
  } i2cmsc_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } i2cmsc_bus_ev_t;

  typedef enum logic [9:0] {
    M_IDLE  = 10'h001,
    M_WAIT  = 10'h002,
    M_START = 10'h004,
    M_HOLD  = 10'h008,
    M_LOW   = 10'h010,
    M_HIGH  = 10'h020,
    M_RS1   = 10'h040,
    M_RS2   = 10'h080,
    M_P1    = 10'h100,
    M_P2    = 10'h200
  } i2cmsc_mstate_t;

  typedef enum logic [4:0] {
    R_NONE = 5'h01,
    R_MTX  = 5'h02,
    R_MRX  = 5'h04,
    R_SRX  = 5'h08,
    R_STX  = 5'h10
  } i2cmsc_role_t;

endpackage

//--- i2cmsc_slave_model.sv
`timescale 1ns/10ps
// ----------------
// far-side slave
// ----------------
// acks only the first byte after each start; ninth low phase counted from start
module i2cmsc_slave_model (
  // bus wires
  input  wire logic scl,
  input  wire logic sda,
  // open-drain data drive
  output logic      sda_oe
);
  int cnt;
  initial begin
    sda_oe = 1'b0;
    cnt    = 0;
  end
  always @(negedge sda) begin
    if (scl) cnt = 0;
  end
  always @(negedge scl) begin
    cnt    = cnt + 1;
    sda_oe = (cnt == 9);
  end
endmodule // i2cmsc_slave_model
